// [include/dffp_consts.vh]
// constants for the dual field-memory fifo port control
// assumes a single 250 MHz system clock; all link pins sampled as levels
`ifndef DFFP_CONSTS_VH
`define DFFP_CONSTS_VH

// storage shape of one port
`define DFFP_DEPTH        262214
`define DFFP_AW           19
`define DFFP_DW           8
`define DFFP_PORTS        2

// words that stay in the serial write stage before reaching the array
`define DFFP_LAG          70
// address width of the serial write stage, sized to hold two fields' tails
`define DFFP_QAW          8

// spacing figures the partner must honour, in clock cycles of the link; the power-up wait is in microseconds
`define DFFP_NEW_SPACING  600
`define DFFP_MIN_ACTIVE   80
`define DFFP_POWERUP_US   100

`endif

// [src/dffp_store.v]
// one port's field storage: serial write stage plus the storage array
// assumes push and rd_req are single-cycle pulses in the clk domain
`timescale 1ns/1ps
`default_nettype none
`include "dffp_consts.vh"

module dffp_store #(
    parameter DEPTH = `DFFP_DEPTH,
    parameter AW    = `DFFP_AW,
    parameter DW    = `DFFP_DW,
    parameter LAG   = `DFFP_LAG,
    parameter QAW   = `DFFP_QAW
) (
    input  wire          clk,
    input  wire          reset,
    input  wire          push,
    input  wire          push_store,
    input  wire          push_new_field,
    input  wire [AW-1:0] push_addr,
    input  wire [DW-1:0] push_data,
    input  wire          rd_req,
    input  wire [AW-1:0] rd_addr,
    output reg  [DW-1:0] rd_data_q
);

    localparam         QD       = 1 << QAW;
    localparam [QAW:0] LAG_CNT  = LAG[QAW:0];
    localparam [QAW:0] FULL_CNT = QD[QAW:0];
    localparam [QAW:0] ONE_CNT  = {{QAW{1'b0}}, 1'b1};

    ////////////////////////////////////////////////////////////////////////////
    // storage array and serial write stage
    reg [DW-1:0]  mem [0:DEPTH-1];
    reg [AW-1:0]  qa  [0:QD-1];
    reg [DW-1:0]  qd  [0:QD-1];
    reg           qs  [0:QD-1];
    reg           qg  [0:QD-1];
    reg [QAW-1:0] head_q;
    reg [QAW-1:0] tail_q;
    reg [QAW:0]   cnt_q;
    reg           gen_q;

    // a new field flips the generation so the old tail can be told apart
    wire gen_d = gen_q ^ push_new_field;

    // old-field words drain at once after a clear; current-field words
    // stay LAG advances deep so a trailing reader still sees the old field
    wire pop = (cnt_q != {(QAW+1){1'b0}}) &&
               ((qg[tail_q] != gen_q) || (cnt_q > LAG_CNT) || (cnt_q == FULL_CNT));

    ////////////////////////////////////////////////////////////////////////////
    // stage pointers and occupancy
    always @(posedge clk) begin
        if (reset) begin
            head_q <= {QAW{1'b0}};
            tail_q <= {QAW{1'b0}};
            cnt_q  <= {(QAW+1){1'b0}};
            gen_q  <= 1'b0;
        end else begin
            gen_q <= gen_d;
            if (push)
                head_q <= head_q + 1'b1;
            if (pop)
                tail_q <= tail_q + 1'b1;
            case ({push, pop})
                2'b10:   cnt_q <= cnt_q + ONE_CNT;
                2'b01:   cnt_q <= cnt_q - ONE_CNT;
                default: cnt_q <= cnt_q;
            endcase
        end
    end

    // array side has no reset: contents are undefined until written
    always @(posedge clk) begin
        if (push) begin
            qa[head_q] <= push_addr;
            qd[head_q] <= push_data;
            qs[head_q] <= push_store;  // masked advances move the pointer only
            qg[head_q] <= gen_d;
        end
        if (pop && qs[tail_q])
            mem[qa[tail_q]] <= qd[tail_q];
    end

    ////////////////////////////////////////////////////////////////////////////
    // read port
    always @(posedge clk) begin
        if (reset)
            rd_data_q <= {DW{1'b0}};
        else if (rd_req)
            rd_data_q <= mem[rd_addr];
    end

endmodule

`default_nettype wire

// [src/dffp_top.v]
// dual field-memory fifo: write and read port control for two 8-bit ports
// assumes every link pin, the three link clocks included, is synchronous
// to clk and sampled as a level; link clocks are far slower than clk
//
// Behaviour
// - last written words wait in the serial stage until a write clear.
// - write controls can act one write clock later than read controls.
// - latency select low accepts data on the control-sampling edge.
// - latency select high accepts data on the following write edge.
// - write advance moves the pointer; mask also high stores the word.
// - read advance moves the read pointer; output drive enables the outputs.
// - two identical ports, own write clocks, one shared read clock.
// - read clear after the next write clear returns the latest field.
// - read clear within 70 writes after write clear returns the old field.
// - pointers wrap at the depth; reads beyond it alias to location zero, writes normal.
`timescale 1ns/1ps
`default_nettype none
`include "dffp_consts.vh"

module dffp_top #(
    parameter DEPTH = `DFFP_DEPTH,
    parameter AW    = `DFFP_AW,
    parameter DW    = `DFFP_DW,
    parameter LAG   = `DFFP_LAG,
    parameter QAW   = `DFFP_QAW
) (
    input  wire          clk,
    input  wire          reset,
    input  wire          write_latency_select,
    input  wire          write_clock_a,
    input  wire          write_pointer_clear_a,
    input  wire          write_advance_a,
    input  wire          input_mask_a,
    input  wire [DW-1:0] write_data_a,
    input  wire          write_clock_b,
    input  wire          write_pointer_clear_b,
    input  wire          write_advance_b,
    input  wire          input_mask_b,
    input  wire [DW-1:0] write_data_b,
    input  wire          shared_read_clock,
    input  wire          read_pointer_clear_a,
    input  wire          read_advance_a,
    input  wire          output_drive_a,
    input  wire          read_pointer_clear_b,
    input  wire          read_advance_b,
    input  wire          output_drive_b,
    output wire [DW-1:0] read_data_a,
    output wire          read_data_oe_a,
    output wire [DW-1:0] read_data_b,
    output wire          read_data_oe_b
);

    localparam          NPORT     = `DFFP_PORTS;
    localparam [AW-1:0] LAST_ADDR = DEPTH[AW-1:0] - 1'b1;
    localparam [AW-1:0] ZERO_ADDR = {AW{1'b0}};

    // next address with wrap at the array depth; past the depth the
    // reader simply aliases, so writing is never disturbed
    function [AW-1:0] next_addr;
        input [AW-1:0] a;
        begin
            if (a == LAST_ADDR)
                next_addr = ZERO_ADDR;
            else
                next_addr = a + 1'b1;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // per-port pin groups gathered so both ports share one description
    wire [NPORT-1:0]    wclk_v  = {write_clock_b, write_clock_a};
    wire [NPORT-1:0]    wclr_v  = {write_pointer_clear_b, write_pointer_clear_a};
    wire [NPORT-1:0]    wadv_v  = {write_advance_b, write_advance_a};
    wire [NPORT-1:0]    wmsk_v  = {input_mask_b, input_mask_a};
    wire [NPORT*DW-1:0] wdata_v = {write_data_b, write_data_a};
    wire [NPORT-1:0]    rclr_v  = {read_pointer_clear_b, read_pointer_clear_a};
    wire [NPORT-1:0]    radv_v  = {read_advance_b, read_advance_a};
    wire [NPORT-1:0]    rdrv_v  = {output_drive_b, output_drive_a};

    ////////////////////////////////////////////////////////////////////////////
    // shared read clock edge; one edge serves both ports
    reg  rclk_prev_q;
    wire rrise = shared_read_clock & ~rclk_prev_q;

    always @(posedge clk) begin
        if (reset)
            rclk_prev_q <= 1'b0;
        else
            rclk_prev_q <= shared_read_clock;
    end

    ////////////////////////////////////////////////////////////////////////////
    // one identical control slice per port
    genvar i;
    generate
        for (i = 0; i < NPORT; i = i + 1) begin : g_port
            reg          wclk_prev_q;
            reg          clr_s_q;
            reg          adv_s_q;
            reg          msk_s_q;
            reg [AW-1:0] wptr_q;
            reg [AW-1:0] rptr_q;
            reg          rd_req_q;
            reg          drv_s_q;
            reg [DW-1:0] rdata_q;
            reg          oe_q;
            wire [DW-1:0] store_data;

            // each port runs on its own write clock edge
            wire wrise = wclk_v[i] & ~wclk_prev_q;

            // latency select high uses the controls caught at the previous
            // write edge against this edge's data, which lets a cascaded
            // device sit one clock behind without an external delay stage
            wire clr_e = write_latency_select ? clr_s_q : wclr_v[i];
            wire adv_e = write_latency_select ? adv_s_q : wadv_v[i];
            wire msk_e = write_latency_select ? msk_s_q : wmsk_v[i];

            // a clear writes its own cycle's word to location zero
            wire [AW-1:0] waddr = clr_e ? ZERO_ADDR : wptr_q;
            wire          push  = wrise & adv_e;
            wire          nfld  = wrise & clr_e;

            // read clear likewise restarts at location zero on its own edge
            wire [AW-1:0] raddr = rclr_v[i] ? ZERO_ADDR : rptr_q;

            // write-side sampling and pointer
            always @(posedge clk) begin
                if (reset) begin
                    wclk_prev_q <= 1'b0;
                    clr_s_q     <= 1'b0;
                    adv_s_q     <= 1'b0;
                    msk_s_q     <= 1'b0;
                    wptr_q      <= ZERO_ADDR;
                end else begin
                    wclk_prev_q <= wclk_v[i];
                    if (wrise) begin
                        clr_s_q <= wclr_v[i];
                        adv_s_q <= wadv_v[i];
                        msk_s_q <= wmsk_v[i];
                        if (adv_e)
                            wptr_q <= next_addr(waddr);
                        else
                            wptr_q <= waddr;  // frozen, or zero on a clear; store nothing
                    end
                end
            end

            // read-side pointer: advance moves it, the drive level only
            // decides whether the word appears on the outputs
            always @(posedge clk) begin
                if (reset) begin
                    rptr_q   <= ZERO_ADDR;
                    rd_req_q <= 1'b0;
                    drv_s_q  <= 1'b0;
                end else begin
                    rd_req_q <= rrise;
                    if (rrise) begin
                        drv_s_q <= rdrv_v[i];
                        if (radv_v[i])
                            rptr_q <= next_addr(raddr);
                        else
                            rptr_q <= raddr;
                    end
                end
            end

            // output flops: word and drive enable change together, two clk
            // after the read edge, well inside one read clock period
            always @(posedge clk) begin
                if (reset) begin
                    rdata_q <= {DW{1'b0}};
                    oe_q    <= 1'b0;
                end else if (rd_req_q) begin
                    rdata_q <= store_data;
                    oe_q    <= drv_s_q;
                end
            end

            // storage with the serial stage that holds back the current field's last words
            dffp_store #(
                .DEPTH (DEPTH),
                .AW    (AW),
                .DW    (DW),
                .LAG   (LAG),
                .QAW   (QAW)
            ) u_store (
                .clk            (clk),
                .reset          (reset),
                .push           (push),
                .push_store     (msk_e),
                .push_new_field (nfld),
                .push_addr      (waddr),
                .push_data      (wdata_v[i*DW +: DW]),
                .rd_req         (rrise),
                .rd_addr        (raddr),
                .rd_data_q      (store_data)
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // outputs come straight from the per-port flops
    assign read_data_a    = g_port[0].rdata_q;
    assign read_data_oe_a = g_port[0].oe_q;
    assign read_data_b    = g_port[1].rdata_q;
    assign read_data_oe_b = g_port[1].oe_q;

endmodule

`default_nettype wire

// [tb/dffp_props.sv]
// checker for dffp_top: read answer timing, output hold and reset values
// assumes link clocks are levels sampled by clk and held low through reset
`timescale 1ns/1ps
`default_nettype none
module dffp_props #(
    parameter DW = 8
) (
    input wire logic          clk,
    input wire logic          reset,
    input wire logic          shared_read_clock,
    input wire logic          output_drive_a,
    input wire logic          output_drive_b,
    input wire logic [DW-1:0] read_data_a,
    input wire logic          read_data_oe_a,
    input wire logic [DW-1:0] read_data_b,
    input wire logic          read_data_oe_b
);
    logic rck_q;
    logic e1_q;
    logic e2_q;
    logic e3_q;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////////////////////////
    // read edge history; an answer may only land two or three clk after an edge
    always @(posedge clk) begin
        rck_q <= shared_read_clock && !reset;
        e1_q  <= shared_read_clock && !rck_q && !reset;
        e2_q  <= e1_q && !reset;
        e3_q  <= e2_q && !reset;
    end
    // a read edge is a low to high step of the shared read clock
    sequence rd_edge_s;
        shared_read_clock && !rck_q;
    endsequence
    // no read edge lies two or three clk back, so no answer may land now
    sequence quiet_s;
        !e2_q && !e3_q;
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    a_drive_oe_a: assert property (rd_edge_s ##0 output_drive_a |-> ##[2:3] read_data_oe_a)
        else $error("port a output not driven after driven read");
    a_drive_oe_b: assert property (rd_edge_s ##0 output_drive_b |-> ##[2:3] read_data_oe_b)
        else $error("port b output not driven after driven read");
    a_float_oe_a: assert property (rd_edge_s ##0 !output_drive_a |-> ##[2:3] !read_data_oe_a)
        else $error("port a output driven without output drive");
    a_float_oe_b: assert property (rd_edge_s ##0 !output_drive_b |-> ##[2:3] !read_data_oe_b)
        else $error("port b output driven without output drive");
    a_hold_out_a: assert property (quiet_s |-> $stable(read_data_a) && $stable(read_data_oe_a))
        else $error("port a output changed without a read edge");
    a_hold_out_b: assert property (quiet_s |-> $stable(read_data_b) && $stable(read_data_oe_b))
        else $error("port b output changed without a read edge");
    a_reset_out_a: assert property (disable iff (1'b0) reset |=> read_data_a == '0 && !read_data_oe_a)
        else $error("port a output not cleared by reset");
    a_reset_out_b: assert property (disable iff (1'b0) reset |=> read_data_b == '0 && !read_data_oe_b)
        else $error("port b output not cleared by reset");
endmodule
`default_nettype wire

// [tb/dffp_video.sv]
// video-side partner: makes both write clocks and the shared read clock
// assumes the caller sets controls just before each call and holds them
`timescale 1ns/1ps
`default_nettype none
module dffp_video (
    input  wire logic clk,
    output var  logic wclk_a,
    output var  logic wclk_b,
    output var  logic rclk
);
    // link clocks stand low between cycles; they never free-run
    initial begin
        {wclk_a, wclk_b, rclk} = 3'h0;
    end
    // one link cycle: four clk high, four low, above the three-clk minimum
    task automatic tick(input logic w, input logic r);
        {wclk_a, wclk_b} = {w, w};
        rclk = r;
        repeat (4) @(posedge clk);
        #1;
        {wclk_a, wclk_b, rclk} = 3'h0;
        repeat (4) @(posedge clk);
        #1;
    endtask
endmodule
`default_nettype wire

// [tb/tb.sv]
// testbench for dffp_top: fields through both ports, old data, reset
// assumes a 1024-word build; port b gets the inverted words of port a
`timescale 1ns/1ps
`default_nettype none
`include "dffp_consts.vh"
typedef struct packed {logic clr; logic adv; logic drv; logic [7:0] idx; logic oe;} dffp_row_t;
module tb;
    logic       clk = 1'b0;
    logic       reset = 1'b1;
    logic       write_latency_select = 1'b0;
    logic       write_pointer_clear_a = 1'b0;
    logic       write_advance_a = 1'b0;
    logic       input_mask_a = 1'b0;
    logic [7:0] write_data_a = 8'h00;
    logic       read_pointer_clear_a = 1'b0;
    logic       read_advance_a = 1'b0;
    logic       output_drive_a = 1'b0;
    wire        write_clock_a, write_clock_b, shared_read_clock, read_data_oe_a, read_data_oe_b;
    wire  [7:0] read_data_a, read_data_b;
    logic [7:0] ea [0:1023];
    int         err_count = 0;
    int         check_count = 0;
    localparam int CLK_PER_US = 250;                   // 4 ns clock
    localparam int NEW_LAG    = `DFFP_NEW_SPACING + 1; // reads trail by more than the spacing
    dffp_row_t  rows [0:5] = '{'{1, 1, 1, 0, 1}, '{0, 0, 1, 1, 1}, '{0, 1, 1, 1, 1},
                               '{0, 1, 0, 2, 0}, '{0, 0, 0, 3, 0}, '{0, 1, 1, 3, 1}};
    ////////////////////////////////////////////////////////////////////////////////
    // shortened depth keeps the run brief; the serial stage lag stays at 70
    dffp_top #(.DEPTH(1024), .AW(10)) dut (.clk, .reset, .write_latency_select, .write_clock_a,
        .write_pointer_clear_a, .write_advance_a, .input_mask_a, .write_data_a, .write_clock_b,
        .write_pointer_clear_b(write_pointer_clear_a), .write_advance_b(write_advance_a),
        .input_mask_b(input_mask_a), .write_data_b(~write_data_a), .shared_read_clock,
        .read_pointer_clear_a, .read_advance_a, .output_drive_a,
        .read_pointer_clear_b(read_pointer_clear_a), .read_advance_b(read_advance_a),
        .output_drive_b(output_drive_a), .read_data_a, .read_data_oe_a, .read_data_b,
        .read_data_oe_b);
    dffp_video p (.clk, .wclk_a(write_clock_a), .wclk_b(write_clock_b), .rclk(shared_read_clock));
    always #2 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic close_out;
        if (err_count == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp || $isunknown(exp)) begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            err_count++;
        end
    endtask
    // both ports read word s+j; a clear starts the sequence only when s is 0
    task automatic rfield(input int s, input int n);
        for (int j = 0; j < n; j++) begin
            {read_pointer_clear_a, read_advance_a, output_drive_a} = {s == 0 && j == 0, 2'b11};
            p.tick(1'b0, 1'b1);
            chk(read_data_a, ea[s+j]);
            chk(read_data_b, ~ea[s+j]);
            chk({7'h00, read_data_oe_a}, 8'h01);
        end
    endtask
    // field write; h adds a masked run and a halt; reads restart d writes behind, 0 = none;
    // below the stage lag the reads see the prior field, so ea keeps it
    task automatic wfield(input logic m, input logic [7:0] key, input int n, input logic h,
                          input int d);
        int   a;
        logic old;
        a = 0;
        old = d > 0 && d < `DFFP_LAG;
        write_latency_select = m;
        for (int j = 0; j <= n; j++) begin
            write_pointer_clear_a = (j == 0);
            write_advance_a = (j < n) && !(h && j == 50);
            input_mask_a = !(h && j >= 10 && j < 20);
            write_data_a = key ^ 8'(j);
            {read_pointer_clear_a, read_advance_a, output_drive_a} = {j == d, 2'b11};
            // mode 1 pairs these controls with the next edge's word
            if (write_advance_a && !old && input_mask_a) ea[a] = key ^ 8'(j + m);
            if (write_advance_a) a++;
            p.tick(1'b1, d > 0 && j < n);
            if (d > 0 && j >= d && j < n) chk(read_data_a, ea[j-d]);
            if (d > 0 && j >= d && j < n) chk(read_data_b, ~ea[j-d]);
        end
        write_advance_a = 1'b0;
        write_pointer_clear_a = !old;
        p.tick(1'b1, 1'b0);
        write_pointer_clear_a = 1'b0;
        p.tick(1'b1, 1'b0);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // watchdog, far beyond the roughly 36000 clk the sequence needs
    initial begin
        #300000;
        err_count++;
        close_out();
    end
    // main sequence: initialise, table of read cases, then the awkward cases
    initial begin
        repeat (12) @(posedge clk);
        #1;
        reset = 1'b0;
        repeat (`DFFP_POWERUP_US * CLK_PER_US) @(posedge clk);
        #1;
        // a clear before and after the dummies covers an unsettled start as well
        for (int i = 0; i < `DFFP_MIN_ACTIVE; i++) begin
            {write_pointer_clear_a, read_pointer_clear_a} = {2{i == 0}};
            p.tick(1'b1, 1'b1);
        end
        {write_pointer_clear_a, read_pointer_clear_a} = 2'b11;
        p.tick(1'b1, 1'b1);
        wfield(1'b0, 8'h11, 100, 1'b0, 0);
        foreach (rows[i]) begin
            {read_pointer_clear_a, read_advance_a, output_drive_a} =
                {rows[i].clr, rows[i].adv, rows[i].drv};
            p.tick(1'b0, 1'b1);
            chk({6'h00, read_data_oe_b, read_data_oe_a}, {6'h00, {2{rows[i].oe}}});
            if (rows[i].oe) chk(read_data_a, ea[rows[i].idx]);
        end
        rfield(4, 80);
        wfield(1'b1, 8'h5A, 100, 1'b1, 0);
        rfield(0, 100);
        write_latency_select = 1'b0;
        wfield(1'b0, 8'h96, NEW_LAG + `DFFP_MIN_ACTIVE, 1'b0, NEW_LAG);
        wfield(1'b0, 8'hC3, 130, 1'b0, 30);
        reset = 1'b1;
        repeat (12) @(posedge clk);
        #1;
        chk(read_data_a | read_data_b | {7'h00, read_data_oe_a | read_data_oe_b}, 8'h00);
        reset = 1'b0;
        close_out();
    end
endmodule
bind dffp_top dffp_props #(.DW(DW)) chk_i (.clk, .reset, .shared_read_clock, .output_drive_a,
    .output_drive_b, .read_data_a, .read_data_oe_a, .read_data_b, .read_data_oe_b);
`default_nettype wire
